// ---- wft_pkg.sv ----
/*
  constants for the watchdog action and timer freeze control block:
  register offsets, byte addresses, field positions, reset values, timing.
  assumes a 200 MHz system clock and a 32-bit AXI4-Lite register port.
*/
package wft_pkg;
  // printed register offsets, kept as register indices
  localparam logic [31:0] OFS_BASE = 32'h50003100;
  localparam logic [31:0] OFS_WATCHDOG_COUNT_VALUE = 32'h50003100;
  localparam logic [31:0] OFS_WDOG_CTRL = 32'h50003102;
  localparam logic [31:0] OFS_FRZ_SET = 32'h50003300;
  localparam logic [31:0] OFS_FRZ_CLR = 32'h50003302;
  localparam logic [31:0] OFS_DBG_CTRL = 32'h50003304;
  localparam logic [31:0] OFS_IRQ_STAT = 32'h50003310;
  localparam logic [31:0] OFS_IRQ_CLR = 32'h50003312;
  localparam logic [31:0] OFS_IRQ_EN = 32'h50003314;
  // byte address on the bus: four times the index past the base
  localparam int AW = 12;
  localparam logic [AW-1:0] A_WATCHDOG_COUNT_VALUE = AW'((OFS_WATCHDOG_COUNT_VALUE - OFS_BASE) << 2);
  localparam logic [AW-1:0] A_WDOG_CTRL = AW'((OFS_WDOG_CTRL - OFS_BASE) << 2);
  localparam logic [AW-1:0] A_FRZ_SET = AW'((OFS_FRZ_SET - OFS_BASE) << 2);
  localparam logic [AW-1:0] A_FRZ_CLR = AW'((OFS_FRZ_CLR - OFS_BASE) << 2);
  localparam logic [AW-1:0] A_DBG_CTRL = AW'((OFS_DBG_CTRL - OFS_BASE) << 2);
  localparam logic [AW-1:0] A_IRQ_STAT = AW'((OFS_IRQ_STAT - OFS_BASE) << 2);
  localparam logic [AW-1:0] A_IRQ_CLR = AW'((OFS_IRQ_CLR - OFS_BASE) << 2);
  localparam logic [AW-1:0] A_IRQ_EN = AW'((OFS_IRQ_EN - OFS_BASE) << 2);
  // field positions
  localparam int WDOG_HALT_BIT = 3;
  localparam int RADIO_TIMEBASE_HALT_BIT = 2;
  localparam int SOFTWARE_TIMER_HALT_BIT = 1;
  localparam int WAKEUP_TIMER_HALT_BIT = 0;
  localparam int NHALT = 4;
  localparam int ACTION_BIT = 0;
  localparam int DBG_EN_BIT = 0;
  localparam int SIGN_BIT = 8;
  localparam int GUARD_HI = 15;
  localparam int GUARD_LO = 9;
  localparam int IRQ_NMI = 0;
  localparam int IRQ_GUARD = 1;
  localparam int NIRQ = 2;
  // reset values and count levels
  localparam logic [8:0] WATCHDOG_COUNT_VALUE_RST = 9'h0FF;
  localparam logic [8:0] WDOG_NMI_LEVEL = 9'h000;
  localparam logic [8:0] WDOG_FLOOR = 9'h1F0;
  localparam logic ACTION_RST = 1'b0;
  localparam logic DBG_EN_RST = 1'b1;
  localparam logic [NHALT-1:0] HALT_RST = 4'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing: one count step every 10.24 ms
  localparam real WDOG_STEP_MS = 10.24;
  localparam real CLK_MHZ = 200.0;
  localparam int WDOG_STEP_CYC = int'(WDOG_STEP_MS * 1000.0 * CLK_MHZ);
endpackage

// ---- wft_step_gen.sv ----
/*
  step pulse generator for the watchdog count.
  assumes run comes from logic on the same clock; counts only while run.
*/
`timescale 1ns/1ps
`default_nettype none
module wft_step_gen #(
  parameter int STEP_CYC = 2048000
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic run, // count enable, low freezes the divider
  output logic step // one-cycle pulse each period
);
  localparam int CW = $clog2(STEP_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STEP_CYC - 1);
  logic [CW-1:0] div_r;
  logic wrap;

  assign wrap = run && (div_r == LAST);

  // divider holds its place while frozen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_r <= '0;
      step <= 1'b0;
    end
    else
    begin
      step <= wrap;
      if (wrap)
        div_r <= '0;
      else if (run)
        div_r <= div_r + CW'(1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_step_period: assert property (wrap |=> step)
    else $error("step not issued at divider wrap");
  chk_step_frozen: assert property (!run |=> $stable(div_r))
    else $error("divider moved while frozen");
endmodule
`default_nettype wire

// ---- wft_ctrl.sv ----
/*
  watchdog action select, watchdog count and on-chip timer freeze control,
  with an AXI4-Lite register slave and a level interrupt.
  assumes dbg_halt comes from another domain; sw_reset_req is on aclk.
*/
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wft_ctrl #(
  parameter int STEP_CYC = wft_pkg::WDOG_STEP_CYC
) (
  input wire logic aclk, // system clock, 200 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [wft_pkg::AW-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [wft_pkg::AW-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic dbg_halt, // processor halted in debug, async
  input wire logic sw_reset_req, // software reset pulse
  output logic wdog_nmi, // non-maskable interrupt pulse
  output logic wdog_sys_reset, // system reset pulse
  output logic radio_timebase_freeze, // radio timebase stopped
  output logic software_timer_freeze, // software timer stopped
  output logic wakeup_timer_freeze, // wake-up timer stopped
  output logic irq // level interrupt
);
  import wft_pkg::*;

  logic dbg_meta_r;
  logic dbg_halt_s;
  logic action_r;
  logic dbg_en_r;
  logic [NHALT-1:0] halt_r;
  logic [NHALT-1:0] halt_nxt;
  logic [8:0] wd_cnt_r;
  logic [8:0] wd_cnt_nxt;
  logic [NIRQ-1:0] stat_r;
  logic [NIRQ-1:0] stat_ev;
  logic [NIRQ-1:0] stat_clr;
  logic [NIRQ-1:0] irq_en_r;
  logic aw_full_r;
  logic w_full_r;
  logic [AW-1:0] waddr_r;
  logic [31:0] wdat_r;
  logic [3:0] wstb_r;
  logic aw_take;
  logic w_take;
  logic do_wr;
  logic aw_full_nxt;
  logic w_full_nxt;
  logic bvalid_nxt;
  logic ar_take;
  logic rvalid_nxt;
  logic [15:0] wd16;
  logic wr_val;
  logic wr_ctrl;
  logic wr_set;
  logic wr_clr;
  logic wr_dbg;
  logic wr_iclr;
  logic wr_ien;
  logic wr_hit;
  logic reload_ok;
  logic reload_refused;
  logic wd_frozen;
  logic wd_step;
  logic dec_en;
  logic nmi_ev;
  logic fire;
  logic [NHALT-1:0] set_mask;
  logic dbg_all;
  logic [15:0] rd_mux;
  logic rd_hit;

  // debug halt crosses into aclk through two flip-flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dbg_meta_r <= 1'b0;
      dbg_halt_s <= 1'b0;
    end
    else
    begin
      dbg_meta_r <= dbg_halt;
      dbg_halt_s <= dbg_meta_r;
    end
  end

  // write channel handshakes; address and data taken in either order
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign do_wr = aw_full_r && w_full_r && !bvalid;
  assign aw_full_nxt = (aw_full_r || aw_take) && !do_wr;
  assign w_full_nxt = (w_full_r || w_take) && !do_wr;
  assign bvalid_nxt = do_wr || (bvalid && !bready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready <= !aw_full_nxt && !bvalid_nxt;
      wready <= !w_full_nxt && !bvalid_nxt;
      bvalid <= bvalid_nxt;
      if (do_wr)
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // write payload holding registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      waddr_r <= '0;
      wdat_r <= '0;
      wstb_r <= '0;
    end
    else
    begin
      if (aw_take)
        waddr_r <= awaddr;
      if (w_take)
      begin
        wdat_r <= wdata;
        wstb_r <= wstrb;
      end
    end
  end

  // write decode; registers are 16 bits in the low two lanes
  assign wd16 = wdat_r[15:0] & {{8{wstb_r[1]}}, {8{wstb_r[0]}}};
  assign wr_val = do_wr && (waddr_r == A_WATCHDOG_COUNT_VALUE);
  assign wr_ctrl = do_wr && (waddr_r == A_WDOG_CTRL);
  assign wr_set = do_wr && (waddr_r == A_FRZ_SET);
  assign wr_clr = do_wr && (waddr_r == A_FRZ_CLR);
  assign wr_dbg = do_wr && (waddr_r == A_DBG_CTRL);
  assign wr_iclr = do_wr && (waddr_r == A_IRQ_CLR);
  assign wr_ien = do_wr && (waddr_r == A_IRQ_EN);
  assign wr_hit = wr_val || wr_ctrl || wr_set || wr_clr || wr_dbg || wr_iclr
    || wr_ien || (waddr_r == A_IRQ_STAT);

  // reload needs both lanes and a clear guard field
  assign reload_ok = wr_val && (&wstb_r[1:0]) && (wd16[GUARD_HI:GUARD_LO] == '0);
  assign reload_refused = wr_val && !reload_ok;

  // watchdog runs unless debug halt or an allowed software freeze
  assign wd_frozen = dbg_halt_s || (!action_r && halt_r[WDOG_HALT_BIT]);
  assign dec_en = wd_step && !wd_frozen;
  assign nmi_ev = !action_r && dec_en && !reload_ok
    && (wd_cnt_r == WDOG_NMI_LEVEL + 9'h001);
  // final action: floor in mode 0, zero or below in mode 1
  assign fire = action_r ? (wd_cnt_r == WDOG_NMI_LEVEL || wd_cnt_r[SIGN_BIT])
    : (wd_cnt_r[SIGN_BIT] && wd_cnt_r <= WDOG_FLOOR);

  wft_step_gen #(
    .STEP_CYC(STEP_CYC)
  ) u_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(!wd_frozen),
    .step(wd_step)
  );

  // count next value: reset reload, software reload, step down
  always_comb
  begin
    wd_cnt_nxt = wd_cnt_r;
    if (fire)
      wd_cnt_nxt = WATCHDOG_COUNT_VALUE_RST;
    else if (reload_ok)
      wd_cnt_nxt = {1'b0, wd16[7:0]};
    else if (dec_en)
      wd_cnt_nxt = wd_cnt_r - 9'h001;
  end

  // count, action pulses and action select
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wd_cnt_r <= WATCHDOG_COUNT_VALUE_RST;
      wdog_nmi <= 1'b0;
      wdog_sys_reset <= 1'b0;
      action_r <= ACTION_RST;
    end
    else
    begin
      wd_cnt_r <= wd_cnt_nxt;
      wdog_nmi <= nmi_ev;
      wdog_sys_reset <= fire;
      if (fire || sw_reset_req)
        action_r <= ACTION_RST;
      else if (wr_ctrl && wd16[ACTION_BIT])
        action_r <= 1'b1;
    end
  end

  // halt bits: ones set or clear, zeros discarded; a one set to the watchdog halt bit is dropped in mode 1
  assign set_mask = wr_set ? wd16[NHALT-1:0] : '0;
  always_comb
  begin
    halt_nxt = halt_r;
    if (wr_clr)
      halt_nxt = halt_nxt & ~wd16[NHALT-1:0];
    halt_nxt[WDOG_HALT_BIT] = halt_nxt[WDOG_HALT_BIT]
      | (set_mask[WDOG_HALT_BIT] & !action_r);
    halt_nxt[RADIO_TIMEBASE_HALT_BIT:0] = halt_nxt[RADIO_TIMEBASE_HALT_BIT:0]
      | set_mask[RADIO_TIMEBASE_HALT_BIT:0];
  end

  // halt state, debug enable and timer freeze outputs
  assign dbg_all = dbg_en_r && dbg_halt_s;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      halt_r <= HALT_RST;
      dbg_en_r <= DBG_EN_RST;
      radio_timebase_freeze <= 1'b0;
      software_timer_freeze <= 1'b0;
      wakeup_timer_freeze <= 1'b0;
    end
    else
    begin
      halt_r <= halt_nxt;
      if (wr_dbg && wstb_r[0])
        dbg_en_r <= wd16[DBG_EN_BIT];
      radio_timebase_freeze <= halt_r[RADIO_TIMEBASE_HALT_BIT] || dbg_all;
      software_timer_freeze <= halt_r[SOFTWARE_TIMER_HALT_BIT] || dbg_all;
      wakeup_timer_freeze <= halt_r[WAKEUP_TIMER_HALT_BIT] || dbg_all;
    end
  end

  // sticky events: set wins over a clear in the same cycle
  assign stat_ev[IRQ_NMI] = nmi_ev;
  assign stat_ev[IRQ_GUARD] = reload_refused;
  assign stat_clr = wr_iclr ? wd16[NIRQ-1:0] : '0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_r <= '0;
      irq_en_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      stat_r <= (stat_r & ~stat_clr) | stat_ev;
      if (wr_ien)
        irq_en_r <= wd16[NIRQ-1:0];
      irq <= |(stat_r & irq_en_r);
    end
  end

  // read decode and data select
  assign rd_hit = (araddr == A_WATCHDOG_COUNT_VALUE) || (araddr == A_WDOG_CTRL)
    || (araddr == A_FRZ_SET) || (araddr == A_FRZ_CLR) || (araddr == A_DBG_CTRL)
    || (araddr == A_IRQ_STAT) || (araddr == A_IRQ_EN) || (araddr == A_IRQ_CLR);
  assign rd_mux = (araddr == A_WATCHDOG_COUNT_VALUE) ? {7'h00, wd_cnt_r}
    : (araddr == A_WDOG_CTRL) ? {15'h0000, action_r}
    : (araddr == A_FRZ_SET || araddr == A_FRZ_CLR) ? {12'h000, halt_r}
    : (araddr == A_DBG_CTRL) ? {15'h0000, dbg_en_r}
    : (araddr == A_IRQ_STAT) ? {14'h0000, stat_r}
    : (araddr == A_IRQ_EN) ? {14'h0000, irq_en_r}
    : 16'h0000;
  assign ar_take = arvalid && arready;
  assign rvalid_nxt = ar_take || (rvalid && !rready);

  // read channel: one read at a time, answer one cycle after the take
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else
    begin
      arready <= !rvalid_nxt;
      rvalid <= rvalid_nxt;
      if (ar_take)
      begin
        rdata <= {16'h0000, rd_mux};
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_floor;
    !action_r && wd_cnt_r == WDOG_FLOOR;
  endsequence
  sequence s_reset_reload;
    wdog_sys_reset && wd_cnt_r == WATCHDOG_COUNT_VALUE_RST && !action_r;
  endsequence

  chk_floor_reset: assert property (s_floor |=> s_reset_reload)
    else $error("no reset and reload at the floor");
  chk_nmi_at_zero: assert property (nmi_ev |=> wdog_nmi && wd_cnt_r == 9'h000)
    else $error("nmi not raised as count reached zero");
  chk_zero_reset: assert property (action_r && wd_cnt_r == 9'h000 |=> s_reset_reload)
    else $error("mode 1 reset missing at zero");
  chk_mode1_nofreeze: assert property (action_r && !dbg_halt_s |-> !wd_frozen)
    else $error("software froze watchdog in mode 1");
  chk_action_sticky: assert property (action_r && !fire && !sw_reset_req |=> action_r)
    else $error("action bit cleared by software");
  chk_debug_stop: assert property (dbg_halt_s && !fire && !reload_ok
    |=> $stable(wd_cnt_r))
    else $error("watchdog moved during debug halt");
  chk_set_halt: assert property (wr_set && wd16[SOFTWARE_TIMER_HALT_BIT]
    |=> halt_r[SOFTWARE_TIMER_HALT_BIT] ##1 software_timer_freeze)
    else $error("software timer not frozen by set");
  chk_clear_halt: assert property (wr_clr && !wr_set && wd16[RADIO_TIMEBASE_HALT_BIT]
    |=> !halt_r[RADIO_TIMEBASE_HALT_BIT])
    else $error("radio timebase not resumed by clear");
  chk_dbg_freeze: assert property (dbg_en_r && dbg_halt_s
    |=> radio_timebase_freeze && software_timer_freeze && wakeup_timer_freeze)
    else $error("timers not frozen in debug halt");
  chk_guard_block: assert property (reload_refused && !fire && !dec_en
    |=> $stable(wd_cnt_r))
    else $error("reload taken with guard bits set");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/*
  self-checking bench for the watchdog action and timer freeze control block.
  assumes wft_pkg and wft_ctrl are compiled first; drives the AXI4-Lite port,
  the debug halt pin and the software reset pin, and models the registers.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import wft_pkg::*;
  localparam int STEP = 16; // shortened count period
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rv, c1, c2;
  logic dbg_halt = 1'b0, sw_reset_req = 1'b0;
  logic wdog_nmi, wdog_sys_reset, radio_fz, soft_fz, wake_fz;
  int err_total = 0, n_tests = 0, nmi_cnt = 0, rst_cnt = 0, cyc, i, base;
  logic [31:0] seed = 32'hB618;
  // register model: halt bits, action bit, debug enable
  logic [3:0] halt = 4'h0, v;
  logic act = 1'b0, de = 1'b1;

  wft_ctrl #(.STEP_CYC(STEP)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dbg_halt(dbg_halt), .sw_reset_req(sw_reset_req), .wdog_nmi(wdog_nmi),
    .wdog_sys_reset(wdog_sys_reset), .radio_timebase_freeze(radio_fz),
    .software_timer_freeze(soft_fz), .wakeup_timer_freeze(wake_fz), .irq(irq)
  );

  // clock and event counters
  always #2.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    if (aresetn === 1'b1 && wdog_nmi === 1'b1) nmi_cnt <= nmi_cnt + 1;
    if (aresetn === 1'b1 && wdog_sys_reset === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, (got >= lo && got <= hi)}, 32'h1);
  endtask

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
      if (bvalid === 1'b1) begin resp = bresp; bready <= 1'b0; break; end
    end
    if (k == 100) chk(32'hDEAD, 32'h0);
  endtask

  task automatic rd(input logic [AW-1:0] a);
    int k;
    bit ad;
    ad = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (!ad && arready === 1'b1) begin ad = 1; arvalid <= 1'b0; end
      if (rvalid === 1'b1) begin rv = rdata; resp = rresp; rready <= 1'b0; break; end
    end
    if (k == 100) chk(32'hDEAD, 32'h0);
  endtask

  // model-side freeze register writes
  task automatic fset(input logic [3:0] b);
    wr(A_FRZ_SET, {28'h0, b}, 4'h3);
    halt = halt | (b & (act ? 4'h7 : 4'hF));
  endtask
  task automatic fclr(input logic [3:0] b);
    wr(A_FRZ_CLR, {28'h0, b}, 4'h3);
    halt = halt & ~b;
  endtask

  task automatic fz_chk;
    logic [2:0] e;
    repeat (5) @(posedge aclk);
    e = halt[2:0] | {3{de & dbg_halt}};
    chk({29'h0, radio_fz, soft_fz, wake_fz}, {29'h0, e});
  endtask

  task automatic wait_evt(input bit on_nmi, input int lim);
    base = on_nmi ? nmi_cnt : rst_cnt;
    cyc = 0;
    while ((on_nmi ? nmi_cnt : rst_cnt) == base && cyc < lim)
    begin
      @(posedge aclk);
      cyc++;
    end
    if (cyc >= lim) chk(32'hBAD, 32'h0);
  endtask

  task automatic test_end(input string name);
    $display("-- test %s done", name);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  initial
  begin
    repeat (60000) @(posedge aclk);
    err_total++;
    tally_and_finish;
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset values and unmapped place
    rd(A_WATCHDOG_COUNT_VALUE); chk(rv, 32'h0FF);
    rd(A_WDOG_CTRL); chk(rv, 32'h0);
    rd(A_FRZ_SET); chk(rv, 32'h0);
    rd(A_DBG_CTRL); chk(rv, 32'h1);
    rd(A_IRQ_EN); chk(rv, 32'h0);
    rd(12'h100); chk({rv[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(12'h100, 32'h1, 4'hF); chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    test_end("reset");
    // random set and clear traffic on all four halt bits
    for (i = 0; i < 10; i++)
    begin
      seed = lfsr(seed);
      v = seed[3:0];
      if (seed[4]) fset(v);
      else fclr(v);
      rd(A_FRZ_SET); chk(rv, {28'h0, halt});
      fz_chk;
    end
    fclr(4'hF);
    test_end("freeze");
    // software freeze of the count, then resume and step rate
    wr(A_WATCHDOG_COUNT_VALUE, 32'h80, 4'h3);
    fset(4'h8);
    rd(A_WATCHDOG_COUNT_VALUE); c1 = rv;
    repeat (5 * STEP) @(posedge aclk);
    rd(A_WATCHDOG_COUNT_VALUE); chk(rv, c1);
    fclr(4'h8);
    rd(A_WATCHDOG_COUNT_VALUE); c1 = rv;
    repeat (5 * STEP) @(posedge aclk);
    rd(A_WATCHDOG_COUNT_VALUE); chk_in(c1 - rv, 4, 6);
    test_end("count");
    // debug halt with enable on and off
    fset(4'h2);
    dbg_halt <= 1'b1;
    fz_chk;
    rd(A_WATCHDOG_COUNT_VALUE); c1 = rv;
    wr(A_DBG_CTRL, 32'h0, 4'h3);
    de = 1'b0;
    fz_chk;
    repeat (4 * STEP) @(posedge aclk);
    rd(A_WATCHDOG_COUNT_VALUE); chk(rv, c1);
    dbg_halt <= 1'b0;
    fz_chk;
    repeat (3 * STEP) @(posedge aclk);
    rd(A_WATCHDOG_COUNT_VALUE); chk_in(c1 - rv, 2, 4);
    wr(A_DBG_CTRL, 32'h1, 4'h3);
    de = 1'b1;
    rd(A_DBG_CTRL); chk(rv, 32'h1);
    fclr(4'hF);
    test_end("debug");
    // reload guard and interrupt raise, mask and clear
    wr(A_IRQ_CLR, 32'h3, 4'h3);
    wr(A_WATCHDOG_COUNT_VALUE, 32'h40, 4'h3);
    rd(A_WATCHDOG_COUNT_VALUE); chk_in(rv, 32'h3E, 32'h40);
    wr(A_WATCHDOG_COUNT_VALUE, 32'h0205, 4'h3);
    rd(A_WATCHDOG_COUNT_VALUE); chk_in(rv, 32'h3C, 32'h40);
    rd(A_IRQ_STAT); chk(rv, 32'h2);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(A_IRQ_EN, 32'h2, 4'h3);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(A_IRQ_CLR, 32'h2, 4'h3);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(A_IRQ_CLR); chk(rv, 32'h0);
    test_end("guard_irq");
    // mode 0: interrupt at zero, reset at minus sixteen
    base = nmi_cnt;
    wr(A_WATCHDOG_COUNT_VALUE, 32'h2, 4'h3);
    wait_evt(1'b1, 3 * STEP + 8);
    repeat (40) @(posedge aclk);
    rd(A_WATCHDOG_COUNT_VALUE); chk_in(rv, 32'h1F0, 32'h1FE);
    wait_evt(1'b0, 20 * STEP);
    chk_in(cyc, 16 * STEP - 60, 16 * STEP - 30);
    rd(A_WATCHDOG_COUNT_VALUE); chk_in(rv, 32'h0FE, 32'h0FF);
    rd(A_IRQ_STAT); chk(rv, 32'h1);
    test_end("mode0");
    // mode 1: set only by software, freeze ignored, reset at zero
    wr(A_WATCHDOG_COUNT_VALUE, 32'h3, 4'h3);
    wr(A_WDOG_CTRL, 32'h1, 4'h3);
    act = 1'b1;
    wr(A_WDOG_CTRL, 32'h0, 4'h3);
    rd(A_WDOG_CTRL); chk(rv, 32'h1);
    fset(4'h8);
    rd(A_FRZ_SET); chk(rv, {28'h0, halt});
    c2 = nmi_cnt;
    wait_evt(1'b0, 4 * STEP + 8);
    chk(nmi_cnt, c2);
    act = 1'b0;
    rd(A_WDOG_CTRL); chk(rv, 32'h0);
    wr(A_WDOG_CTRL, 32'h1, 4'h3);
    rd(A_WDOG_CTRL); chk(rv, 32'h1);
    @(posedge aclk);
    sw_reset_req <= 1'b1;
    @(posedge aclk);
    sw_reset_req <= 1'b0;
    rd(A_WDOG_CTRL); chk(rv, 32'h0);
    test_end("mode1");
    tally_and_finish;
  end
endmodule
`default_nettype wire
